// >>> rtl/srsv_char_check.sv
// Purpose: per-character parity check, residue code and justification
// Assumes: len code 0..3 means 5..8 bits; bits is 1..8 I-field bits
// Notes: purely combinational
`timescale 1ns/1ns
module srsv_char_check
  import srsv_pkg::*;
(
  input wire srsv_rxc_s rxc_i,
  input wire srsv_ctrl_s ctrl_i,
  output logic par_err_o,
  output logic [2:0] res_o,
  output logic [7:0] data_o
);
  logic [7:0] mask;
  logic [3:0] v;
  logic [3:0] nb;

  always_comb begin
    nb = 4'h5 + {2'h0, ctrl_i.len};
    mask = 8'hff >> (4'h8 - nb);
    // Partial last byte keeps its bits in the low positions
    if (rxc_i.eof && rxc_i.bits < nb) begin
      mask = 8'hff >> (4'h8 - rxc_i.bits);
    end
    data_o = rxc_i.data & mask;
    par_err_o = ctrl_i.par_en &&
      ((^(rxc_i.data & mask) ^ rxc_i.pbit) != ctrl_i.par_odd);
    // Code value steps with I-field bits, offset by character length
    v = rxc_i.bits + 4'h6 + 4'h3 * (4'h3 - {2'h0, ctrl_i.len});
    res_o = {v[0], v[1], v[2]};
  end
endmodule

// >>> rtl/srsv_consts.svh
// Purpose: offsets, fields, reset values and codes of the status block
// Assumes: 32-bit AHB-Lite, one word per register
// Notes: included by srsv_top, the bench and the checker
`ifndef SRSV_CONSTS_SVH
`define SRSV_CONSTS_SVH
`define SRSV_OFS_CTRL 8'h00
`define SRSV_OFS_VECW 8'h04
`define SRSV_OFS_CMD 8'h08
`define SRSV_OFS_DATA 8'h0c
`define SRSV_OFS_STAT 8'h10
`define SRSV_OFS_VRBA 8'h14
`define SRSV_OFS_VRBB 8'h18
`define SRSV_OFS_ISTS 8'h1c
`define SRSV_OFS_ICLR 8'h20
`define SRSV_OFS_IEN 8'h24
`define SRSV_CMD_LSB 3
`define SRSV_CMD_ERR_RESET 3'h6
`define SRSV_MODE_ASYNC 2'h0
`define SRSV_MODE_SYNC 2'h1
`define SRSV_MODE_BITW 2'h2
`define SRSV_CTRL_RST 7'h00
`define SRSV_VEC_RST 8'h00
`define SRSV_IRQ_RX 0
`define SRSV_IRQ_SPC 1
`define SRSV_VEC_NONE 3'h3
`define SRSV_VEC_ASPC 3'h7
`define SRSV_VEC_ARX 3'h6
`define SRSV_FIFO_DEPTH 2'h3
`endif

// >>> rtl/srsv_pkg.sv
// Purpose: types shared by the status block files
// Assumes: constants come from srsv_consts.svh
// Notes: none
package srsv_pkg;
  typedef enum logic [1:0] {
    SRSV_PH_IDLE = 2'b01,
    SRSV_PH_WR = 2'b10
  } srsv_ph_e;

  // Control register: mode, parity enable/odd, vector option, length
  typedef struct packed {
    logic [1:0] mode;
    logic par_en;
    logic par_odd;
    logic sav;
    logic [1:0] len;
  } srsv_ctrl_s;

  // One received character from the receiver core
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic pbit;
    logic fr_err;
    logic crc_err;
    logic eof;
    logic [3:0] bits;
  } srsv_rxc_s;

  typedef struct packed {
    logic [7:0] data;
    logic par;
    logic fr;
    logic ovr;
  } srsv_ent_s;

  typedef struct packed {
    srsv_ph_e ph;
    logic [7:0] wa;
    srsv_ctrl_s ctrl;
    logic [7:0] vec;
    srsv_ent_s [2:0] fifo;
    logic [1:0] rd;
    logic [1:0] cnt;
    logic par_l;
    logic ovr_l;
    logic crc;
    logic eof;
    logic [2:0] res;
    logic [1:0] ists;
    logic [1:0] ien;
    logic [31:0] hrdata;
    logic irq;
    logic ext;
  } srsv_state_s;
endpackage

// >>> rtl/srsv_top.sv
// Purpose: special receive status and vector readback for one channel
// Assumes: receiver, transmitter and other interrupt sources share clk_i
// Notes: AHB-Lite slave, zero wait states, always OKAY
// Function
// - Async: all-sent set only after every character left transmitter.
// - All-sent never interrupts; reads set in synchronous modes.
// - Bitwise mode: residue bits give I-field length, valid with end-of-frame.
// - 8-bit residue codes map bits in last and second-last byte.
// - Residual I-field bits in a received byte are right justified.
// - Frame on character boundary gives length-dependent residue code.
// - Parity mismatch sets parity error, latched until error reset.
// - Fourth unread character overruns; flag latched once that char read.
// - With vector option, overrun raises special receive vector.
// - Async: framing bit set, unlatched, for the faulty character.
// - Framing error extends character time by half a bit.
// - Sync/bitwise: CRC bit shows checker result per character.
// - Bitwise: valid closing flag sets end-of-frame; error reset clears.
// - End-of-frame also updated by first character of next frame.
// - Vector readback: raw vector, or modified when option on.
// - Vector bits 3..1 show top pending condition; none reads 011.
// - Vector readback readable only through the second channel.
// - Vector bits 7..4 and 0 always equal the programmed vector.
//
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "srsv_consts.svh"
module srsv_top
  import srsv_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  input wire srsv_rxc_s rxc_i,
  input wire logic tx_all_sent_i,
  input wire logic [5:0] pend_other_i,
  output logic irq_o,
  output logic rx_extend_o
);
  srsv_state_s q;
  srsv_state_s s;
  logic par_err;
  logic [2:0] res_code;
  logic [7:0] rx_data;
  logic acc;
  logic [1:0] wi;
  logic [1:0] hd;
  logic async;
  logic spc;
  logic [7:0] stat;
  logic [7:0] vrb;
  logic [7:0] pend;
  logic [2:0] vcode;
  logic found;
  logic [2:0] prio [0:7];

  // Fixed priority order of the vector codes, highest first
  assign prio[0] = 3'h7;
  assign prio[1] = 3'h6;
  assign prio[2] = 3'h4;
  assign prio[3] = 3'h5;
  assign prio[4] = 3'h3;
  assign prio[5] = 3'h2;
  assign prio[6] = 3'h0;
  assign prio[7] = 3'h1;

  srsv_char_check u_check (
    .rxc_i(rxc_i),
    .ctrl_i(q.ctrl),
    .par_err_o(par_err),
    .res_o(res_code),
    .data_o(rx_data)
  );

  function automatic logic [1:0] inc3(input logic [1:0] a);
    inc3 = (a == 2'h2) ? 2'h0 : a + 2'h1;
  endfunction

  always_comb begin
    s = q;
    s.ext = 1'b0;
    s.ph = SRSV_PH_IDLE;
    acc = hsel_i & htrans_i[1] & hready_i;
    wi = 2'h0;
    hd = 2'h0;
    stat = 8'h00;
    vrb = 8'h00;
    pend = 8'h00;
    vcode = `SRSV_VEC_NONE;
    found = 1'b0;
    spc = 1'b0;
    async = 1'b0;

    // Write data phase
    if (q.ph == SRSV_PH_WR) begin
      case (q.wa)
        `SRSV_OFS_CTRL: begin
          s.ctrl = hwdata_i[6:0];
        end
        `SRSV_OFS_VECW: begin
          s.vec = hwdata_i[7:0];
        end
        `SRSV_OFS_CMD: begin
          if (hwdata_i[`SRSV_CMD_LSB +: 3] == `SRSV_CMD_ERR_RESET) begin
            s.par_l = 1'b0;
            s.ovr_l = 1'b0;
            s.crc = 1'b0;
            s.eof = 1'b0;
          end
        end
        `SRSV_OFS_ICLR: begin
          s.ists = s.ists & ~hwdata_i[1:0];
        end
        `SRSV_OFS_IEN: begin
          s.ien = hwdata_i[1:0];
        end
        default: begin
        end
      endcase
    end

    async = (s.ctrl.mode == `SRSV_MODE_ASYNC);

    // Status byte: head character flags plus latched bits
    hd = s.rd;
    stat[7] = s.eof;
    stat[6] = async ? (s.cnt != 2'h0 && s.fifo[hd].fr) : s.crc;
    stat[5] = s.ovr_l | (s.cnt != 2'h0 && s.fifo[hd].ovr);
    stat[4] = s.par_l | (s.cnt != 2'h0 && s.fifo[hd].par);
    stat[3:1] = s.res;
    stat[0] = async ? tx_all_sent_i : 1'b1;

    // Highest pending condition picks bits 3..1 of the vector
    pend[5:0] = pend_other_i;
    pend[`SRSV_VEC_ARX] = s.ists[`SRSV_IRQ_RX] & s.ien[`SRSV_IRQ_RX];
    pend[`SRSV_VEC_ASPC] = s.ists[`SRSV_IRQ_SPC] & s.ien[`SRSV_IRQ_SPC];
    for (int i = 0; i < 8; i++) begin
      if (!found && pend[prio[i]]) begin
        found = 1'b1;
        vcode = prio[i];
      end
    end
    vrb = s.vec;
    if (s.ctrl.sav) begin
      vrb[3:1] = vcode;
    end

    // Address phase
    if (acc) begin
      if (hwrite_i) begin
        s.ph = SRSV_PH_WR;
        s.wa = haddr_i[7:0];
        s.hrdata = 32'h0000_0000;
      end else begin
        case (haddr_i[7:0])
          `SRSV_OFS_CTRL: begin
            s.hrdata = {25'h0, s.ctrl};
          end
          `SRSV_OFS_VECW: begin
            s.hrdata = {24'h0, s.vec};
          end
          `SRSV_OFS_DATA: begin
            s.hrdata = {24'h0, s.fifo[hd].data};
            if (s.cnt != 2'h0) begin
              // Parity and overrun errors of the character read stay latched
              if (s.fifo[hd].par) begin
                s.par_l = 1'b1;
              end
              if (s.fifo[hd].ovr) begin
                s.ovr_l = 1'b1;
              end
              s.rd = inc3(s.rd);
              s.cnt = s.cnt - 2'h1;
            end
          end
          `SRSV_OFS_STAT: begin
            s.hrdata = {24'h0, stat};
          end
          `SRSV_OFS_VRBA: begin
            s.hrdata = 32'h0000_0000;
          end
          `SRSV_OFS_VRBB: begin
            s.hrdata = {24'h0, vrb};
          end
          `SRSV_OFS_ISTS: begin
            s.hrdata = {30'h0, s.ists};
          end
          `SRSV_OFS_IEN: begin
            s.hrdata = {30'h0, s.ien};
          end
          default: begin
            s.hrdata = 32'h0000_0000;
          end
        endcase
      end
    end

    // Character arrival, after any pop and clear so the set wins
    if (rxc_i.valid) begin
      if (s.cnt == `SRSV_FIFO_DEPTH) begin
        // Overwrite the newest entry and mark it overrun
        wi = inc3(inc3(s.rd));
        s.fifo[wi].ovr = 1'b1;
        spc = 1'b1;
      end else begin
        wi = s.rd;
        if (s.cnt > 2'h0) begin
          wi = inc3(wi);
        end
        if (s.cnt > 2'h1) begin
          wi = inc3(wi);
        end
        s.fifo[wi].ovr = 1'b0;
        s.cnt = s.cnt + 2'h1;
      end
      s.fifo[wi].data = rx_data;
      s.fifo[wi].par = par_err;
      s.fifo[wi].fr = async & rxc_i.fr_err;
      if (par_err || (async && rxc_i.fr_err)) begin
        spc = 1'b1;
      end
      if (async && rxc_i.fr_err) begin
        s.ext = 1'b1;
      end
      if (!async) begin
        s.crc = rxc_i.crc_err;
      end
      if (s.ctrl.mode == `SRSV_MODE_BITW) begin
        s.eof = rxc_i.eof;
        if (rxc_i.eof) begin
          s.res = res_code;
          spc = 1'b1;
        end
      end
      s.ists[`SRSV_IRQ_RX] = 1'b1;
      if (spc) begin
        s.ists[`SRSV_IRQ_SPC] = 1'b1;
      end
    end

    s.irq = |(s.ists & s.ien);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      q <= '0;
      q.ph <= SRSV_PH_IDLE;
      q.ctrl <= `SRSV_CTRL_RST;
      q.vec <= `SRSV_VEC_RST;
    end else begin
      q <= s;
    end
  end

  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = q.hrdata;
  assign irq_o = q.irq;
  assign rx_extend_o = q.ext;
endmodule

// >>> verification/serial_rx_status_vector_bench.sv
// Purpose: self-checking bench for the status and vector block
// Assumes: host model owns the bus, bench drives characters
// Notes: residue cases come from a table
`timescale 1ns/1ns
`include "srsv_consts.svh"
module serial_rx_status_vector_bench
  import srsv_pkg::*;
;
  localparam logic [7:0] ST = `SRSV_OFS_STAT;
  localparam logic [7:0] DA = `SRSV_OFS_DATA;
  localparam logic [31:0] ER = 32'(`SRSV_CMD_ERR_RESET) << `SRSV_CMD_LSB;
  logic clk_i = 0;
  logic reset_i = 1;
  logic tx_all_sent_i = 0;
  logic [5:0] pend_other_i = '0;
  srsv_rxc_s rxc_i = '0;
  logic rdy, irq, ext, hsel, hwrite, resp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, r;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int i;
  logic [8:0] rows [11] = '{
    {2'd3, 4'd1, 3'b111}, {2'd3, 4'd2, 3'b000}, {2'd3, 4'd3, 3'b100},
    {2'd3, 4'd4, 3'b010}, {2'd3, 4'd5, 3'b110}, {2'd3, 4'd6, 3'b001},
    {2'd3, 4'd7, 3'b101}, {2'd3, 4'd8, 3'b011}, {2'd2, 4'd7, 3'b000},
    {2'd1, 4'd6, 3'b010}, {2'd0, 4'd5, 3'b001}};
  logic [5:0] pv [5] = '{6'h00, 6'h11, 6'h03, 6'h06, 6'h30};
  logic [7:0] ev [5] = '{8'ha7, 8'ha9, 8'ha1, 8'ha5, 8'ha9};
  always #4 clk_i = ~clk_i;
  srsv_top dut (.clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(rdy), .hreadyout_o(rdy), .hresp_o(resp),
    .hrdata_o(hrdata), .rxc_i(rxc_i), .tx_all_sent_i(tx_all_sent_i),
    .pend_other_i(pend_other_i), .irq_o(irq), .rx_extend_o(ext));
  srsv_host host (.clk_i(clk_i), .hready_i(rdy), .hrdata_i(hrdata),
    .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
    .hsize_o(hsize), .hwdata_o(hwdata));
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, r);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, e);
    host.xfer(1'b0, a, 32'h0, r);
    // Every answer must carry the OKAY response
    chk({31'h0, resp}, 32'h0);
    chk(r & m, e);
  endtask
  // Flags are pbit, framing, crc, end of frame
  task automatic ch(input logic [7:0] d, input logic [3:0] f, b);
    rxc_i <= {1'b1, d, f, b};
    @(posedge clk_i);
    rxc_i <= '0;
  endtask
  task automatic cfg(input logic [1:0] m, input logic pe, sv,
    input logic [1:0] l);
    wr(`SRSV_OFS_CTRL, {25'h0, m, pe, 1'b0, sv, l});
  endtask
  task automatic rst();
    reset_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
  endtask
  initial begin
    rst();
    for (i = 0; i < 11; i++) begin
      cfg(`SRSV_MODE_BITW, 1'b0, 1'b0, rows[i][8:7]);
      ch(8'hff, 4'h1, rows[i][6:3]);
      rc(ST, 32'h8e, {24'h0, 4'h8, rows[i][2:0], 1'b0});
      rc(DA, 32'hff, (32'h1 << rows[i][6:3]) - 32'h1);
    end
    ch(8'h55, 4'h0, 4'h8);
    rc(ST, 32'h80, 32'h0);
    rc(DA, 32'hff, 32'h15);
    cfg(`SRSV_MODE_SYNC, 1'b0, 1'b0, 2'h3);
    rc(ST, 32'h1, 32'h1);
    ch(8'h3c, 4'h2, 4'h8);
    rc(ST, 32'h40, 32'h40);
    ch(8'h3c, 4'h0, 4'h8);
    rc(ST, 32'h40, 32'h0);
    rst();
    cfg(`SRSV_MODE_ASYNC, 1'b0, 1'b0, 2'h3);
    rc(ST, 32'h1, 32'h0);
    tx_all_sent_i <= 1'b1;
    @(posedge clk_i);
    rc(ST, 32'h1, 32'h1);
    ch(8'h41, 4'h4, 4'h8);
    rc(ST, 32'h40, 32'h40);
    rc(DA, 32'hff, 32'h41);
    ch(8'h42, 4'h0, 4'h8);
    rc(ST, 32'h40, 32'h0);
    rc(DA, 32'hff, 32'h42);
    cfg(`SRSV_MODE_ASYNC, 1'b1, 1'b0, 2'h3);
    wr(`SRSV_OFS_IEN, 32'h2);
    ch(8'h01, 4'h0, 4'h8);
    rc(ST, 32'h10, 32'h10);
    rc(DA, 32'hff, 32'h01);
    ch(8'h03, 4'h0, 4'h8);
    rc(ST, 32'h10, 32'h10);
    wr(`SRSV_OFS_CMD, ER);
    rc(ST, 32'h10, 32'h0);
    rc(DA, 32'hff, 32'h03);
    wr(`SRSV_OFS_IEN, 32'h0);
    rc(`SRSV_OFS_ISTS, 32'h3, 32'h3);
    chk({31'h0, irq}, 32'h0);
    wr(`SRSV_OFS_ICLR, 32'h3);
    wr(`SRSV_OFS_VECW, 32'ha5);
    rc(`SRSV_OFS_VRBA, 32'hffffffff, 32'h0);
    rc(`SRSV_OFS_VRBB, 32'hffffffff, 32'ha5);
    cfg(`SRSV_MODE_ASYNC, 1'b0, 1'b1, 2'h3);
    wr(`SRSV_OFS_IEN, 32'h2);
    for (i = 0; i < 5; i++) begin
      pend_other_i <= pv[i];
      @(posedge clk_i);
      rc(`SRSV_OFS_VRBB, 32'hffffffff, {24'h0, ev[i]});
    end
    for (i = 0; i < 4; i++) begin
      rxc_i <= {1'b1, 8'h10 + 8'(i), 8'h08};
      @(posedge clk_i);
    end
    rxc_i <= '0;
    rc(`SRSV_OFS_VRBB, 32'hffffffff, 32'haf);
    chk({31'h0, irq}, 32'h1);
    rc(DA, 32'hff, 32'h10);
    rc(ST, 32'h20, 32'h0);
    rc(DA, 32'hff, 32'h11);
    rc(ST, 32'h20, 32'h20);
    rc(DA, 32'hff, 32'h13);
    rc(ST, 32'h20, 32'h20);
    wr(`SRSV_OFS_CMD, ER);
    rc(ST, 32'h20, 32'h0);
    wr(`SRSV_OFS_ICLR, 32'h3);
    rc(8'hfc, 32'hffffffff, 32'h0);
    chk({31'h0, irq}, 32'h0);
    tally_and_finish();
  end
endmodule
bind srsv_top srsv_chk chk (.clk_i(clk_i), .reset_i(reset_i),
  .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
  .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
  .hrdata_o(hrdata_o), .rxc_i(rxc_i), .pend_other_i(pend_other_i),
  .irq_o(irq_o), .rx_extend_o(rx_extend_o));

// >>> verification/srsv_host.sv
// Purpose: host model issuing single word register transfers
// Assumes: one slave whose ready is fed back as hready_i
// Notes: xfer is called right after a rising clock edge
`timescale 1ns/1ns
module srsv_host (
  input wire logic clk_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_i,
  output logic hsel_o,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [2:0] hsize_o,
  output logic [31:0] hwdata_o
);
  initial begin
    hsel_o = 1'b0;
    haddr_o = '0;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o = 3'h2;
    hwdata_o = '0;
  end
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    hsel_o <= 1'b1;
    haddr_o <= {24'h0, a};
    hwrite_o <= w;
    htrans_o <= 2'h2;
    // Stale write data never lingers on the bus
    hwdata_o <= ~hwdata_o;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    htrans_o <= 2'h0;
    hwdata_o <= d;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    r = hrdata_i;
  endtask
endmodule

// >>> verification/srsv_top_chk.sv
// Purpose: port assertions for the status block
// Assumes: zero wait state single word bus transfers
// Notes: mirrors control, vector and enable writes
`timescale 1ns/1ns
`include "srsv_consts.svh"
module srsv_chk
  import srsv_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire srsv_rxc_s rxc_i,
  input wire logic [5:0] pend_other_i,
  input wire logic irq_o,
  input wire logic rx_extend_o
);
  logic tk, rd, rvb, dv_q, dw_q, iw, perr;
  logic [7:0] da_q, vec_q;
  logic [6:0] ctl_q;
  logic [1:0] ien_q;
  assign tk = hsel_i && htrans_i[1] && hready_i;
  assign rd = tk && !hwrite_i;
  assign rvb = rd && haddr_i[7:0] == `SRSV_OFS_VRBB;
  assign iw = dv_q && dw_q && da_q == `SRSV_OFS_IEN;
  assign perr = ctl_q[4] && ((^(rxc_i.data & (8'hff >> (2'h3 - ctl_q[1:0])))
    ^ rxc_i.pbit) != ctl_q[3]);
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dv_q <= 1'b0;
      dw_q <= 1'b0;
      da_q <= '0;
      ctl_q <= '0;
      vec_q <= '0;
      ien_q <= '0;
    end else begin
      dv_q <= tk;
      dw_q <= hwrite_i;
      da_q <= haddr_i[7:0];
      if (dv_q && dw_q) begin
        case (da_q)
          `SRSV_OFS_CTRL: ctl_q <= hwdata_i[6:0];
          `SRSV_OFS_VECW: vec_q <= hwdata_i[7:0];
          `SRSV_OFS_IEN: ien_q <= hwdata_i[1:0];
          default: ;
        endcase
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_vec_fix;
    rvb |=> hrdata_o[7:4] == vec_q[7:4] && hrdata_o[0] == vec_q[0];
  endproperty
  a_vec_fix: assert property (p_vec_fix) else $error("vector fixed bits");
  property p_vec_raw;
    rvb && !ctl_q[2] |=> hrdata_o == {24'h0, vec_q};
  endproperty
  a_vec_raw: assert property (p_vec_raw) else $error("raw vector");
  property p_vec_none;
    rvb && ctl_q[2] && pend_other_i == 6'h0 && !irq_o |=> hrdata_o[3:1] == 3'h3;
  endproperty
  a_vec_none: assert property (p_vec_none) else $error("idle vector");
  property p_vec_a;
    rd && haddr_i[7:0] == `SRSV_OFS_VRBA |=> hrdata_o == 32'h0;
  endproperty
  a_vec_a: assert property (p_vec_a) else $error("first channel vector");
  property p_sync_sent;
    rd && haddr_i[7:0] == `SRSV_OFS_STAT && ctl_q[6:5] == `SRSV_MODE_SYNC
      |=> hrdata_o[0];
  endproperty
  a_sync_sent: assert property (p_sync_sent) else $error("sync all sent");
  property p_ext;
    rx_extend_o == $past(rxc_i.valid && rxc_i.fr_err
      && ctl_q[6:5] == `SRSV_MODE_ASYNC);
  endproperty
  a_ext: assert property (p_ext) else $error("half bit stretch");
  property p_irq_src;
    $rose(irq_o) |-> $past(rxc_i.valid) || $past(iw) || $past(iw, 2);
  endproperty
  a_irq_src: assert property (p_irq_src) else $error("stray interrupt");
  property p_par;
    ien_q == 2'h2 && rxc_i.valid && perr |-> ##[1:2] irq_o;
  endproperty
  a_par: assert property (p_par) else $error("parity interrupt");
endmodule
